// ===== tiv_top.sv
// triple-redundant input voter: input tables, voting, discrepancy, shutdown, outputs
// assumes bus receivers, peers' checksums and scan tick come from this clock domain
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ns

// Behaviour
// [RULE1] two or three source groups: each voted bit is majority of three copies
// [RULE2] single source group: its value passes through unchanged
// [RULE3] discrete copy with discrepancy, self-test or module fault is excluded
// [RULE4] per group degradation: 3-2-1-0 or 3-2-default
// [RULE5] three analog copies: middle value goes to the voted table
// [RULE6] two analog copies: high, low or average per group config
// [RULE7] one valid analog copy: it is the voted result
// [RULE8] faulted analog copies dropped, degrading per group path
// [RULE9] discrete discrepancy when one copy persistently disagrees with the others
// [RULE10] analog discrepancy when a channel deviates from middle over threshold percent
// [RULE11] discrepancy logs entry naming the disagreeing copy, readable by software
// [RULE12] discrepancy checks only for groups with reporting enabled
// [RULE13] vote before each application cycle into voted table; raw copies readable
// [RULE14] each bus path writes its own input table
// [RULE15] eligible discrete fault starts repair timer; expiry forces safe state
// [RULE16] safe state: outputs off, discrete inputs take group default; code zeroes only the copied redundant word whose index is the shut group
// [RULE17] pending shutdown status bit; control bit cancels or prevents shutdown
// [RULE18] delay from self-test interval, reset from config, rewritable by software
// [RULE19] redundant output words first, non-voted after
// [RULE20] logic outputs copied into separate physical area
// [RULE21] each scan sends non-voted plus copied outputs
// [RULE22] checksum compared with both peers; optional halt when both disagree
// [RULE23] shutdown after three intervals unless fault clears or cancelled
// [RULE24] per-copy valid flag; valid count selects voting mode
module tiv_top
    import tiv_pkg::*;
#(
    parameter int TICK_CYC    = tiv_pkg::TICK_CYCLES,
    parameter int INTERVAL_CF = tiv_pkg::INTERVAL_MS
) (
    input  wire logic                              clock,
    input  wire logic                              sys_rst,
    input  wire logic [7:0]                        addr,
    input  wire logic [31:0]                       wdata,
    input  wire logic                              wr_stb,
    input  wire logic                              rd_stb,
    output logic      [31:0]                       rdata,
    input  wire logic [2:0]                        bus_wr,
    input  wire logic [2:0][1:0]                   bus_grp,
    input  wire tiv_pkg::tiv_copy_t [2:0]          bus_copy,
    input  wire logic                              scan_tick,
    input  wire logic [31:0]                       own_cksum,
    input  wire logic [1:0][31:0]                  peer_cksum,
    output logic                                   vote_done,
    output logic                                   out_stb,
    output logic      [2:0]                        out_idx,
    output logic      [31:0]                       out_word,
    output logic                                   shut_pending,
    output logic                                   cpu_halt
);
    import tiv_pkg::*;

    function automatic logic [DW-1:0] maj3(input logic [DW-1:0] a, b, c);
        return (a & b) | (a & c) | (b & c);
    endfunction

    function automatic logic [AW-1:0] mid3(input logic [AW-1:0] a, b, c);
        if ((a >= b) == (a <= c))
            return a;
        else if ((b >= a) == (b <= c))
            return b;
        else
            return c;
    endfunction

    function automatic logic [AW-1:0] adiff(input logic [AW-1:0] a, b);
        return (a > b) ? a - b : b - a;
    endfunction

    tiv_copy_t        tbl_r   [NGRP][NCPY];
    logic [31:0]      gcfg_r  [NGRP];
    logic [31:0]      gdef_r  [NGRP];
    logic [DW-1:0]    vdisc_r [NGRP];
    logic [AW-1:0]    vana_r  [NGRP];
    logic [31:0]      outl_r  [NOUT];
    logic [31:0]      outp_r  [NRED];
    logic [NCPY-1:0]  dflag_r [NGRP];
    logic [1:0]       dcnt_r  [NGRP][NCPY];
    logic [NGRP-1:0]  shut_r;
    logic [2:0]       ctrl_r;
    logic [31:0]      intv_r;
    tiv_flog_t        flog_r;
    logic             flog_new_r;
    logic [31:0]      tick_r;
    logic [33:0]      ms_r;
    logic [3:0]       tx_r;
    logic             halt_r;

    logic [NCPY-1:0]  valid_c [NGRP];
    logic [NCPY-1:0]  disc_hit [NGRP];
    logic [NCPY-1:0]  ana_hit [NGRP];
    logic [NGRP-1:0]  elig;
    logic [DW-1:0]    vdisc_nxt [NGRP];
    logic [AW-1:0]    vana_nxt [NGRP];
    logic             clr;
    logic             pend_nxt;

    assign clr = wr_stb && addr == REG_CTRL && wdata[CTRL_CLEAR];

    // each bus path owns its table; copies never overwrite each other
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int g = 0; g < NGRP; g++)
                for (int c = 0; c < NCPY; c++)
                    tbl_r[g][c] <= '0;
        end else begin
            for (int c = 0; c < NCPY; c++)
                if (bus_wr[c])
                    tbl_r[bus_grp[c]][c] <= bus_copy[c]; // RULE14
        end
    end

    // validity, discrepancy detection and vote, all groups in parallel
    always_comb begin
        elig = '0;
        for (int g = 0; g < NGRP; g++) begin
            logic [1:0]    nsrc;
            logic [1:0]    nv;
            logic [DW-1:0] dd;
            logic [AW-1:0] a0, a1, a2, mid, lo, hi;
            logic [AW:0]   sum;
            tiv_copy_t     one;
            nsrc = gcfg_r[g][GC_NSRC_LO +: 2];
            nv = 2'h0;
            one = tbl_r[g][0];
            for (int c = 0; c < NCPY; c++) begin
                // any fault on the copy drops its valid flag
                valid_c[g][c] = (c < nsrc) && !tbl_r[g][c].mod_fault // RULE24
                    && !tbl_r[g][c].test_fault && !dflag_r[g][c]; // RULE3 RULE8
                nv = nv + {1'b0, valid_c[g][c]};
            end
            for (int c = NCPY - 1; c >= 0; c--)
                if (valid_c[g][c])
                    one = tbl_r[g][c];
            a0 = tbl_r[g][0].ana;
            a1 = tbl_r[g][1].ana;
            a2 = tbl_r[g][2].ana;
            mid = mid3(a0, a1, a2);
            dd = maj3(tbl_r[g][0].disc, tbl_r[g][1].disc, tbl_r[g][2].disc);
            for (int c = 0; c < NCPY; c++) begin
                // only full three-copy groups with reporting on are checked
                disc_hit[g][c] = gcfg_r[g][GC_DISC_EN] && nsrc == 2'h3 // RULE12
                    && |(tbl_r[g][c].disc ^ dd); // RULE9
                ana_hit[g][c] = gcfg_r[g][GC_DISC_EN] && nsrc == 2'h3
                    && (24'(adiff(tbl_r[g][c].ana, mid)) * 24'd100
                        > 24'(gcfg_r[g][GC_PCT_LO +: 8]) * 24'(mid)); // RULE10
            end
            // discrete vote; with two valid copies a split falls back to default
            if (shut_r[g])
                vdisc_nxt[g] = gdef_r[g][DW-1:0]; // RULE16
            else if (nsrc == 2'h1)
                vdisc_nxt[g] = valid_c[g][0] ? tbl_r[g][0].disc
                                             : gdef_r[g][DW-1:0]; // RULE2
            else if (nv == 2'h3)
                vdisc_nxt[g] = dd; // RULE1
            else if (nv == 2'h2)
                vdisc_nxt[g] = maj3(valid_c[g][0] ? tbl_r[g][0].disc : gdef_r[g][DW-1:0],
                    valid_c[g][1] ? tbl_r[g][1].disc : gdef_r[g][DW-1:0],
                    valid_c[g][2] ? tbl_r[g][2].disc : gdef_r[g][DW-1:0]); // RULE1
            else if (nv == 2'h1 && gcfg_r[g][GC_PATH321])
                vdisc_nxt[g] = one.disc; // RULE4
            else
                vdisc_nxt[g] = gdef_r[g][DW-1:0]; // RULE4
            // analog vote on valid copies only
            lo = '1;
            hi = '0;
            sum = '0;
            for (int c = 0; c < NCPY; c++)
                if (valid_c[g][c]) begin
                    lo = (tbl_r[g][c].ana < lo) ? tbl_r[g][c].ana : lo;
                    hi = (tbl_r[g][c].ana > hi) ? tbl_r[g][c].ana : hi;
                    sum = sum + {1'b0, tbl_r[g][c].ana};
                end
            if (nv == 2'h3)
                vana_nxt[g] = mid; // RULE5
            else if (nv == 2'h2)
                case (gcfg_r[g][GC_TWO_LO +: 2])
                    TWO_HIGH: vana_nxt[g] = hi; // RULE6
                    TWO_LOW:  vana_nxt[g] = lo;
                    default:  vana_nxt[g] = sum[AW:1];
                endcase
            else if (nv == 2'h1 && (gcfg_r[g][GC_PATH321] || nsrc == 2'h1))
                vana_nxt[g] = one.ana; // RULE7
            else
                vana_nxt[g] = gdef_r[g][31:16]; // RULE8
            for (int c = 0; c < NCPY; c++)
                if (dflag_r[g][c] || (c < nsrc && tbl_r[g][c].test_fault))
                    elig[g] = !shut_r[g]; // RULE15
        end
    end

    // voted table written on the scan tick, before the application runs
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int g = 0; g < NGRP; g++) begin
                vdisc_r[g] <= '0;
                vana_r[g] <= '0;
            end
            vote_done <= 1'b0;
        end else begin
            if (scan_tick)
                for (int g = 0; g < NGRP; g++) begin
                    vdisc_r[g] <= vdisc_nxt[g]; // RULE13
                    vana_r[g] <= vana_nxt[g];
                end
            vote_done <= scan_tick;
        end
    end

    // persistence counters and sticky discrepancy flags; a new hit beats clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int g = 0; g < NGRP; g++) begin
                dflag_r[g] <= '0;
                for (int c = 0; c < NCPY; c++)
                    dcnt_r[g][c] <= 2'h0;
            end
        end else begin
            for (int g = 0; g < NGRP; g++)
                for (int c = 0; c < NCPY; c++) begin
                    if (scan_tick)
                        dcnt_r[g][c] <= !disc_hit[g][c] ? 2'h0
                            : (dcnt_r[g][c] == DISC_PERSIST) ? dcnt_r[g][c]
                            : dcnt_r[g][c] + 2'h1;
                    if (scan_tick && ((disc_hit[g][c] && dcnt_r[g][c] + 2'h1 >= DISC_PERSIST)
                            || ana_hit[g][c]))
                        dflag_r[g][c] <= 1'b1; // RULE9 RULE10
                    else if (clr)
                        dflag_r[g][c] <= 1'b0;
                end
        end
    end

    // fault log keeps the newest discrepancy; reading it clears the new mark
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flog_r <= '0;
            flog_new_r <= 1'b0;
        end else begin
            logic hit;
            hit = 1'b0;
            for (int g = 0; g < NGRP; g++)
                for (int c = 0; c < NCPY; c++)
                    if (scan_tick && !hit && !dflag_r[g][c] && (ana_hit[g][c]
                            || (disc_hit[g][c] && dcnt_r[g][c] + 2'h1 >= DISC_PERSIST))) begin
                        hit = 1'b1;
                        flog_r <= '{valid: 1'b1, analog: ana_hit[g][c],
                                    grp: 2'(g), cpy: 2'(c)}; // RULE11
                    end
            if (hit)
                flog_new_r <= 1'b1;
            else if (rd_stb && addr == REG_FLOG)
                flog_new_r <= 1'b0;
        end
    end

    // repair timer in ms ticks; limit is three self-test intervals
    assign pend_nxt = |elig && !ctrl_r[CTRL_CANCEL]; // RULE17
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tick_r <= '0;
            ms_r <= '0;
            shut_r <= '0;
            shut_pending <= 1'b0;
        end else begin
            shut_pending <= pend_nxt; // RULE17
            if (!pend_nxt) begin
                tick_r <= '0;
                ms_r <= '0; // RULE23
            end else if (tick_r == 32'(TICK_CYC - 1)) begin
                tick_r <= '0;
                ms_r <= ms_r + 34'h1;
            end else begin
                tick_r <= tick_r + 32'h1;
            end
            // an expiry in the same cycle as a clear still shuts
            if (pend_nxt && ms_r >= 34'(SHUT_INTERVALS) * {2'h0, intv_r})
                shut_r <= (clr ? '0 : shut_r) | elig; // RULE15 RULE23
            else if (clr)
                shut_r <= '0;
        end
    end

    // software registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_r <= '0;
            intv_r <= 32'(INTERVAL_CF); // RULE18
            for (int g = 0; g < NGRP; g++) begin
                gcfg_r[g] <= GCFG_RST;
                gdef_r[g] <= '0;
            end
            for (int i = 0; i < NOUT; i++)
                outl_r[i] <= '0;
        end else if (wr_stb) begin
            if (addr == REG_CTRL)
                ctrl_r <= {1'b0, wdata[CTRL_HALTEN], wdata[CTRL_CANCEL]};
            else if (addr == REG_INTERVAL)
                intv_r <= wdata; // RULE18
            else if (addr >= REG_GCFG && addr < REG_GCFG + 8'h10)
                gcfg_r[addr[3:2]] <= wdata;
            else if (addr >= REG_GDEF && addr < REG_GDEF + 8'h10)
                gdef_r[addr[3:2]] <= wdata;
            else if (addr >= REG_OUT && addr < REG_OUT + 8'(4 * NOUT))
                outl_r[addr[4:2]] <= wdata; // RULE19
        end
    end

    // read port, data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata <= '0;
        end else if (rd_stb) begin
            if (addr == REG_CTRL)
                rdata <= {29'h0, ctrl_r};
            else if (addr == REG_STATUS)
                rdata <= {24'h0, shut_r, flog_new_r, halt_r, |shut_r, shut_pending};
            else if (addr == REG_INTERVAL)
                rdata <= intv_r;
            else if (addr == REG_FLOG)
                rdata <= {23'h0, flog_r.valid, 3'h0, flog_r.analog, flog_r.grp, flog_r.cpy};
            else if (addr >= REG_GCFG && addr < REG_GCFG + 8'h10)
                rdata <= gcfg_r[addr[3:2]];
            else if (addr >= REG_GDEF && addr < REG_GDEF + 8'h10)
                rdata <= gdef_r[addr[3:2]];
            else if (addr >= REG_VOTED && addr < REG_VOTED + 8'h10)
                rdata <= {vana_r[addr[3:2]], vdisc_r[addr[3:2]]};
            else if (addr >= REG_RAW && addr < REG_RAW + 8'h30)
                rdata <= {tbl_r[2'((addr - REG_RAW) / 8'd12)][2'(addr[5:2] % 4'd3)].ana,
                          tbl_r[2'((addr - REG_RAW) / 8'd12)][2'(addr[5:2] % 4'd3)].disc}; // RULE13
            else if (addr >= REG_OUT && addr < REG_OUT + 8'(4 * NOUT))
                rdata <= outl_r[addr[4:2]];
            else
                rdata <= '0;
        end else begin
            rdata <= '0;
        end
    end

    // physical copy on each scan so self-test never touches logic outputs
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < NRED; i++)
                outp_r[i] <= '0;
        end else if (scan_tick) begin
            for (int i = 0; i < NRED; i++)
                outp_r[i] <= shut_r[i] ? 32'h0 : outl_r[i]; // RULE20 RULE16
        end
    end

    // send sequence: copied redundant words then non-voted, one per cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_r <= 4'h0;
            out_stb <= 1'b0;
            out_idx <= '0;
            out_word <= '0;
        end else begin
            out_stb <= 1'b0;
            if (vote_done)
                tx_r <= 4'h1;
            else if (tx_r != 4'h0) begin
                out_stb <= 1'b1; // RULE21
                out_idx <= 3'(tx_r - 4'h1);
                out_word <= (tx_r - 4'h1 < 4'(NRED)) ? outp_r[2'(tx_r - 4'h1)]
                                                    : outl_r[3'(tx_r - 4'h1)];
                tx_r <= (tx_r == 4'(NOUT)) ? 4'h0 : tx_r + 4'h1;
            end
        end
    end

    // checksum compare with both peers on each scan; halt only if enabled
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            halt_r <= 1'b0;
            cpu_halt <= 1'b0;
        end else begin
            if (scan_tick && own_cksum != peer_cksum[0] && own_cksum != peer_cksum[1])
                halt_r <= 1'b1; // RULE22
            cpu_halt <= halt_r && ctrl_r[CTRL_HALTEN];
        end
    end

    logic [AW-1:0] hi_of0;
    logic [AW-1:0] lo_of0;

    a_vote_three: assert property (@(posedge clock) disable iff (sys_rst) // RULE1
        scan_tick && valid_c[0] == 3'h7 && !shut_r[0] |=> vdisc_r[0] == $past(
            maj3(tbl_r[0][0].disc, tbl_r[0][1].disc, tbl_r[0][2].disc)))
        else $error("voted bits not majority");
    a_shut_default: assert property (@(posedge clock) disable iff (sys_rst) // RULE16
        scan_tick && shut_r[0] |=> vdisc_r[0] == gdef_r[0][DW-1:0] && outp_r[0] == 32'h0)
        else $error("shut group not at safe state");
    a_mid_value: assert property (@(posedge clock) disable iff (sys_rst) // RULE5
        scan_tick && valid_c[0] == 3'h7 |=> vana_r[0] <= $past(hi_of0) && vana_r[0] >= $past(lo_of0))
        else $error("analog vote outside copies");
    a_pending_cancel: assert property (@(posedge clock) disable iff (sys_rst) // RULE17
        ctrl_r[CTRL_CANCEL] |=> !shut_pending)
        else $error("pending set while cancelled");
    a_shut_timer: assert property (@(posedge clock) disable iff (sys_rst) // RULE23
        $rose(|shut_r) |-> $past(ms_r) >= 34'(SHUT_INTERVALS) * {2'h0, $past(intv_r)} || $past(clr))
        else $error("shutdown before three intervals");
    a_disc_enable: assert property (@(posedge clock) disable iff (sys_rst) // RULE12
        !gcfg_r[2][GC_DISC_EN] |-> disc_hit[2] == 3'h0 && ana_hit[2] == 3'h0)
        else $error("check on disabled group");
    a_log_entry: assert property (@(posedge clock) disable iff (sys_rst) // RULE11
        scan_tick && ana_hit[0][2] && dflag_r[0] == 3'h0 && !(|ana_hit[0][1:0])
        && !(|disc_hit[0]) |=> flog_new_r && flog_r.grp == 2'h0 && flog_r.cpy == 2'h2)
        else $error("log entry missing copy");
    a_tx_order: assert property (@(posedge clock) disable iff (sys_rst) // RULE21
        vote_done |=> ##1 out_stb && out_idx == 3'h0 ##7 out_stb && out_idx == 3'h7)
        else $error("output send sequence wrong");

    assign hi_of0 = (a_max(tbl_r[0][0].ana, tbl_r[0][1].ana) > tbl_r[0][2].ana)
        ? a_max(tbl_r[0][0].ana, tbl_r[0][1].ana) : tbl_r[0][2].ana;
    assign lo_of0 = (a_min(tbl_r[0][0].ana, tbl_r[0][1].ana) < tbl_r[0][2].ana)
        ? a_min(tbl_r[0][0].ana, tbl_r[0][1].ana) : tbl_r[0][2].ana;

    function automatic logic [AW-1:0] a_max(input logic [AW-1:0] a, b);
        return (a > b) ? a : b;
    endfunction

    function automatic logic [AW-1:0] a_min(input logic [AW-1:0] a, b);
        return (a < b) ? a : b;
    endfunction
endmodule

// ===== tiv_pkg.sv
// package for the triple-redundant input voter: sizes, register map, fields
// assumes a single scan clock shared by bus receivers, application and voter
package tiv_pkg;
    localparam int NGRP = 4;                  // input groups
    localparam int NCPY = 3;                  // copies a, b, c
    localparam int DW   = 16;                 // discrete bits per group
    localparam int AW   = 16;                 // analog channel width
    localparam int NOUT = 8;                  // output table words
    localparam int NRED = 4;                  // redundant words at the table start
    localparam int CLK_MHZ        = 125;
    localparam int TICK_MS        = 1;        // timer resolution in ms
    localparam int TICK_CYCLES    = TICK_MS * CLK_MHZ * 1000;
    localparam int INTERVAL_MS    = 28800000; // 8 h start-up self-test interval
    localparam int SHUT_INTERVALS = 3;
    localparam logic [1:0] DISC_PERSIST = 2'h2; // scans of disagreement
    // register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_INTERVAL = 8'h08;
    localparam logic [7:0] REG_FLOG     = 8'h0c;
    localparam logic [7:0] REG_GCFG     = 8'h20; // + 4*group
    localparam logic [7:0] REG_GDEF     = 8'h40; // + 4*group
    localparam logic [7:0] REG_VOTED    = 8'h60; // + 4*group
    localparam logic [7:0] REG_RAW      = 8'h80; // + 4*(3*group+copy)
    localparam logic [7:0] REG_OUT      = 8'hc0; // + 4*word
    // ctrl fields
    localparam int CTRL_CANCEL = 0;
    localparam int CTRL_HALTEN = 1;
    localparam int CTRL_CLEAR  = 2;
    // group config fields
    localparam int GC_DISC_EN = 0;
    localparam int GC_PATH321 = 1;
    localparam int GC_TWO_LO  = 2;            // two-copy mode, 2 bits
    localparam int GC_PCT_LO  = 4;            // threshold percent, 8 bits
    localparam int GC_NSRC_LO = 12;           // source modules, 2 bits
    localparam logic [31:0] GCFG_RST = 32'h0000_3001;
    localparam logic [1:0] TWO_HIGH = 2'h0;
    localparam logic [1:0] TWO_LOW  = 2'h1;
    localparam logic [1:0] TWO_AVG  = 2'h2;

    typedef struct packed {
        logic [AW-1:0] ana;
        logic [DW-1:0] disc;
        logic          mod_fault;
        logic          test_fault;
    } tiv_copy_t;

    typedef struct packed {
        logic       valid;
        logic       analog;
        logic [1:0] grp;
        logic [1:0] cpy;
    } tiv_flog_t;
endpackage

// ===== tiv_field.sv
// field input modules on the three buses: one copy struct per path per write
// assumes the bench calls send just after a rising clock edge
`timescale 1ns/1ns
module tiv_field
    import tiv_pkg::*;
(
    input  wire logic                clock,
    output logic [2:0]               bus_wr,
    output logic [2:0][1:0]          bus_grp,
    output tiv_pkg::tiv_copy_t [2:0] bus_copy
);
    initial begin
        bus_wr   = 3'h0;
        bus_grp  = '0;
        bus_copy = '0;
    end
    // all three modules broadcast together, each on its own bus
    task automatic send(input logic [1:0] g, input tiv_copy_t [2:0] c);
        bus_wr   <= 3'h7;
        bus_grp  <= {g, g, g};
        bus_copy <= c;
        @(posedge clock);
        bus_wr   <= 3'h0;
        bus_copy <= ~c; // released data must not look like the last copy
        @(posedge clock);
    endtask
endmodule

// ===== tmr_input_voter_tb.sv
// bench: register tasks, behavioural vote model, shutdown sequence
// assumes tiv_field drives the bus paths on the same clock
`timescale 1ns/1ns
module tmr_input_voter_tb;
    import tiv_pkg::*;
    logic            clock, sys_rst, wr_stb, rd_stb, scan_tick;
    logic            vote_done, out_stb, shut_pending, halt;
    logic [7:0]      addr;
    logic [31:0]     wdata, rdata, out_word, d, w0, w5, ck;
    logic [63:0]     pk;
    logic [2:0]      bus_wr, out_idx;
    logic [2:0][1:0] bus_grp;
    tiv_copy_t [2:0] bus_copy, v;
    logic [31:0]     ow [8];
    logic [15:0]     e, df;
    int              err_total, checked, n;
    tiv_top #(.TICK_CYC(4), .INTERVAL_CF(2)) uut (.clock(clock), .sys_rst(sys_rst),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .bus_wr(bus_wr), .bus_grp(bus_grp), .bus_copy(bus_copy), .scan_tick(scan_tick),
        .own_cksum(ck), .peer_cksum(pk), .vote_done(vote_done), .out_stb(out_stb),
        .out_idx(out_idx), .out_word(out_word), .shut_pending(shut_pending), .cpu_halt(halt));
    tiv_field fld (.clock(clock), .bus_wr(bus_wr), .bus_grp(bus_grp), .bus_copy(bus_copy));
    // keep the last streamed word of each index
    always @(posedge clock) if (out_stb) ow[out_idx] <= out_word;
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic chk(input string s, input logic [31:0] g, x);
        checked++;
        if (g !== x) begin
            err_total++;
            $display("Error %s exp %h got %h", s, x, g);
        end
    endtask
    // strobes drop then an edge passes, so back-to-back calls never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        addr   <= a;
        wdata  <= x;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rc(input string s, input logic [7:0] a, input logic [31:0] x);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 d = rdata;
        chk(s, d, x);
        @(posedge clock);
    endtask
    task automatic scan();
        scan_tick <= 1'b1;
        @(posedge clock);
        scan_tick <= 1'b0;
        #1 chk("vote_done", 32'(vote_done), 32'h1);
        repeat (10) @(posedge clock);
    endtask
    task automatic mk();
        for (int c = 0; c < 3; c++) v[c] = {16'($urandom), 16'($urandom), 2'h0};
    endtask
    function automatic logic [15:0] med(input logic [15:0] x, y, z);
        logic [15:0] lo;
        logic [15:0] hi;
        lo = (x < y) ? x : y;
        hi = (x < y) ? y : x;
        return (z < lo) ? lo : ((z > hi) ? hi : z);
    endfunction
    task automatic print_verdict();
        if (err_total == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #300000 err_total++;
        print_verdict();
    end
    initial begin
        {wr_stb, rd_stb, scan_tick, addr, wdata, ck, pk} = 139'h0;
        sys_rst = 1'b1;
        n = $urandom(32'ha03cf2a1);
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rc("gcfg", REG_GCFG, GCFG_RST);
        rc("interval", REG_INTERVAL, 32'h2);
        rc("unmapped", 8'h10, 32'h0);
        // three clean copies with checking off: pure majority and mid-value
        for (int g = 0; g < NGRP; g++) begin
            wr(REG_GCFG + 8'(4 * g), 32'h3000);
            mk();
            fld.send(2'(g), v);
            scan();
            rc("voted", REG_VOTED + 8'(4 * g), {med(v[0].ana, v[1].ana, v[2].ana),
                (v[0].disc & v[1].disc) | (v[0].disc & v[2].disc) | (v[1].disc & v[2].disc)});
            for (int c = 0; c < 3; c++) rc("raw", REG_RAW + 8'(12 * g + 4 * c), {v[c].ana, v[c].disc});
        end
        wr(REG_GCFG + 8'h4, 32'h1000);
        mk();
        fld.send(2'h1, v);
        scan();
        rc("single", REG_VOTED + 8'h4, {v[0].ana, v[0].disc});
        // copy c faulted: two-copy analog modes, discrete votes against default 0
        for (int m = 0; m < 3; m++) begin
            wr(REG_GCFG + 8'h8, 32'h3000 | 32'(m << 2));
            mk();
            v[2].mod_fault = 1'b1;
            v[1].ana[0] = v[0].ana[0];
            fld.send(2'h2, v);
            scan();
            e = (v[0].ana > v[1].ana) == (m == 0) ? v[0].ana : v[1].ana;
            if (m == 2) e = 16'((17'(v[0].ana) + 17'(v[1].ana)) >> 1);
            rc("two", REG_VOTED + 8'h8, {e, v[0].disc & v[1].disc});
        end
        // group 0 at 10 percent: copy c far off the middle is flagged and logged
        wr(REG_GCFG, 32'h30a1);
        mk();
        v[1] = v[0];
        v[2] = v[0];
        v[2].ana[15] = ~v[0].ana[15];
        fld.send(2'h0, v);
        scan();
        rc("flagged", REG_STATUS, 32'h9);
        rc("log", REG_FLOG, 32'h112);
        wr(REG_CTRL, 32'h4);
        wr(REG_GCFG, 32'h3000);
        // self-test fault on group 0 runs the repair timer into shutdown
        df = 16'($urandom);
        w0 = $urandom | 32'h1;
        w5 = $urandom;
        wr(REG_GDEF, {16'h0, df});
        wr(REG_OUT, w0);
        wr(REG_OUT + 8'h14, w5);
        mk();
        v[0].test_fault = 1'b1;
        fld.send(2'h0, v);
        scan();
        chk("pending", 32'(shut_pending), 32'h1);
        chk("out0a", ow[0], w0);
        // shut lands 25 cycles (3 x 2 ms x 4, plus one) after the table write; 12 are gone
        for (n = 0; n < 100 && shut_pending === 1'b1; n++) @(posedge clock);
        rc("status", REG_STATUS, 32'h12);
        chk("shut", 32'(d[4]), 32'h1);
        chk("delay", 32'(n >= 14 && n <= 15), 32'h1);
        scan();
        rc("default", REG_VOTED, {(v[1].ana > v[2].ana) ? v[1].ana : v[2].ana, df});
        chk("out0", ow[0], 32'h0);
        chk("out5", ow[5], w5);
        // clearing the shutdown rearms the pending timer, cancel drops it
        wr(REG_CTRL, 32'h4);
        rc("rearm", REG_STATUS, 32'h1);
        wr(REG_CTRL, 32'h1);
        for (n = 0; n < 8 && shut_pending; n++) @(posedge clock);
        chk("cancel", 32'(shut_pending), 32'h0);
        // one peer agreeing is no halt, both disagreeing is
        wr(REG_CTRL, 32'h3);
        ck <= 32'h5;
        pk[63:32] <= 32'h5;
        scan();
        chk("halt1", 32'(halt), 32'h0);
        pk[63:32] <= 32'h6;
        scan();
        chk("halt2", 32'(halt), 32'h1);
        print_verdict();
    end
endmodule
